// ---- inc/hbi_pkg.sv ----
package hbi_pkg;

    localparam int HBI_DATA_W = 64;
    localparam int HBI_ADDR_W = 32;
    localparam int HBI_LANES = 4;
    localparam int HBI_LANE_W = 16;
    localparam int HBI_LOW_LIMIT = 8;
    localparam int HBI_LINE_PHASES = 8;
    localparam int HBI_PHASE_W = 3;
    localparam int HBI_LINE_W = HBI_DATA_W * HBI_LINE_PHASES;
    localparam int HBI_WIN_HI = 31;
    localparam int HBI_WIN_LO = 20;
    localparam logic [11:0] HBI_IRQ_WINDOW = 12'hfee;
    localparam logic [3:0] HBI_FLAG_IDLE = 4'hf;
    localparam logic [63:0] HBI_LINE_IDLE = 64'hffff_ffff_ffff_ffff;
    localparam logic HBI_SRC_HUB = 1'b0;
    localparam logic HBI_SRC_GFX = 1'b1;
    localparam logic [2:0] HBI_LAST_PHASE = 3'h7;

    typedef enum logic [1:0] {
        HBI_D_IDLE = 2'b00,
        HBI_D_GRANT = 2'b01,
        HBI_D_SEND = 2'b10
    } hbi_dev_state_t;

    typedef enum logic [1:0] {
        HBI_H_IDLE = 2'b00,
        HBI_H_REQ = 2'b01,
        HBI_H_DRIVE = 2'b11
    } hbi_host_state_t;

    // Number of logic ones in a lane, i.e. lines that would sit low when driven plainly
    function automatic logic [4:0] hbi_ones(input logic [HBI_LANE_W-1:0] v);
        logic [4:0] n;
        n = 5'h00;
        for (int i = 0; i < HBI_LANE_W; i++) begin
            n = n + {4'h0, v[i]};
        end
        return n;
    endfunction : hbi_ones

    // Returns {flags_n, lines_n}; lines are active low
    function automatic logic [HBI_DATA_W+HBI_LANES-1:0] hbi_encode(input logic [HBI_DATA_W-1:0] d);
        logic [HBI_DATA_W-1:0] lines;
        logic [HBI_LANES-1:0] flags;
        lines = ~d;
        flags = HBI_FLAG_IDLE;
        for (int i = 0; i < HBI_LANES; i++) begin
            if (hbi_ones(d[i*HBI_LANE_W +: HBI_LANE_W]) > 5'(HBI_LOW_LIMIT)) begin
                lines[i*HBI_LANE_W +: HBI_LANE_W] = d[i*HBI_LANE_W +: HBI_LANE_W];
                flags[i] = 1'b0;
            end
        end
        return {flags, lines};
    endfunction : hbi_encode

    function automatic logic [HBI_DATA_W-1:0] hbi_decode(input logic [HBI_DATA_W-1:0] lines,
                                                          input logic [HBI_LANES-1:0] flags_n);
        logic [HBI_DATA_W-1:0] d;
        d = ~lines;
        for (int i = 0; i < HBI_LANES; i++) begin
            if (!flags_n[i]) begin
                d[i*HBI_LANE_W +: HBI_LANE_W] = lines[i*HBI_LANE_W +: HBI_LANE_W];
            end
        end
        return d;
    endfunction : hbi_decode

endpackage : hbi_pkg

// ---- inc/hbi_link_if.sv ----
`timescale 1ns/1ps
interface hbi_link_if import hbi_pkg::*; (
    input wire logic link_clk
);
    logic [HBI_DATA_W-1:0] dev_data_o;
    logic [HBI_LANES-1:0] dev_flag_o;
    logic dev_data_oe;
    logic [HBI_DATA_W-1:0] host_data_o;
    logic [HBI_LANES-1:0] host_flag_o;
    logic host_data_oe;
    logic [HBI_DATA_W-1:0] host_data_line_n;
    logic [HBI_LANES-1:0] lane_invert_flag_n;
    logic host_req;
    logic dev_gnt;
    logic msg_strobe;
    logic [HBI_ADDR_W-1:0] msg_addr;

    // Undriven lines float high through termination
    assign host_data_line_n = dev_data_oe ? dev_data_o : (host_data_oe ? host_data_o : HBI_LINE_IDLE);
    assign lane_invert_flag_n = dev_data_oe ? dev_flag_o : (host_data_oe ? host_flag_o : HBI_FLAG_IDLE);

    modport dev (
        input link_clk,
        output dev_data_o,
        output dev_flag_o,
        output dev_data_oe,
        input host_data_oe,
        input host_data_line_n,
        input lane_invert_flag_n,
        input host_req,
        output dev_gnt,
        output msg_strobe,
        output msg_addr
    );

    modport host (
        input link_clk,
        output host_data_o,
        output host_flag_o,
        output host_data_oe,
        input dev_data_oe,
        input host_data_line_n,
        input lane_invert_flag_n,
        output host_req,
        input dev_gnt,
        input msg_strobe,
        input msg_addr
    );
endinterface : hbi_link_if

// ---- src/hbi_dev_end.sv ----
`timescale 1ns/1ps
module hbi_dev_end import hbi_pkg::*; (
    input wire logic clock,
    input wire logic rst,
    hbi_link_if.dev link,
    input wire logic in_valid,
    output logic in_ready_r,
    input wire logic [HBI_ADDR_W-1:0] in_addr,
    input wire logic [HBI_DATA_W-1:0] in_data,
    input wire logic in_src,
    input wire logic in_pci_sem,
    output logic rx_valid_r,
    output logic [HBI_DATA_W-1:0] rx_data_r,
    output logic [HBI_PHASE_W-1:0] rx_phase_r
);
    logic req_tgl_r;
    logic ack_s1_r;
    logic ack_s2_r;
    logic ack_s3_r;
    logic ack_edge;
    logic [HBI_ADDR_W-1:0] buf_addr_r;
    logic [HBI_DATA_W-1:0] buf_data_r;
    logic buf_src_r;
    logic buf_pci_r;

    logic lrst_s1_r;
    logic lrst_r;
    logic req_s1_r;
    logic req_s2_r;
    logic req_s3_r;
    logic req_edge;
    logic pend_r;
    logic ack_tgl_r;
    logic irq_hit;
    logic [HBI_DATA_W+HBI_LANES-1:0] enc;
    logic [HBI_PHASE_W-1:0] phase_cnt_r;
    hbi_dev_state_t state_r;
    logic dev_data_oe_r;
    logic [HBI_DATA_W-1:0] dev_data_r;
    logic [HBI_LANES-1:0] dev_flag_r;
    logic dev_gnt_r;
    logic msg_strobe_r;
    logic [HBI_ADDR_W-1:0] msg_addr_r;

    assign link.dev_data_oe = dev_data_oe_r;
    assign link.dev_data_o = dev_data_r;
    assign link.dev_flag_o = dev_flag_r;
    assign link.dev_gnt = dev_gnt_r;
    assign link.msg_strobe = msg_strobe_r;
    assign link.msg_addr = msg_addr_r;

    // Single posting slot; a full slot refuses the next write, which the source retries
    always_ff @(posedge clock) begin
        if (rst) begin
            in_ready_r <= 1'b1;
            req_tgl_r <= 1'b0;
        end else if (in_valid && in_ready_r) begin
            in_ready_r <= 1'b0;
            req_tgl_r <= ~req_tgl_r;
        end else if (ack_edge) begin
            in_ready_r <= 1'b1;
        end
    end

    // Slot contents stay frozen until the link side acknowledges, so they cross as stable words
    always_ff @(posedge clock) begin
        if (in_valid && in_ready_r) begin
            buf_addr_r <= in_addr;
            buf_data_r <= in_data;
            buf_src_r <= in_src;
            buf_pci_r <= in_pci_sem;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            ack_s1_r <= 1'b0;
            ack_s2_r <= 1'b0;
            ack_s3_r <= 1'b0;
        end else begin
            ack_s1_r <= ack_tgl_r;
            ack_s2_r <= ack_s1_r;
            ack_s3_r <= ack_s2_r;
        end
    end

    assign ack_edge = ack_s2_r ^ ack_s3_r;

    always_ff @(posedge link.link_clk) begin
        lrst_s1_r <= rst;
        lrst_r <= lrst_s1_r;
    end

    always_ff @(posedge link.link_clk) begin
        if (lrst_r) begin
            req_s1_r <= 1'b0;
            req_s2_r <= 1'b0;
            req_s3_r <= 1'b0;
        end else begin
            req_s1_r <= req_tgl_r;
            req_s2_r <= req_s1_r;
            req_s3_r <= req_s2_r;
        end
    end

    assign req_edge = req_s2_r ^ req_s3_r;

    // Decode looks only at a write already held in the slot
    assign irq_hit = pend_r && (buf_addr_r[HBI_WIN_HI:HBI_WIN_LO] == HBI_IRQ_WINDOW)
                     && (buf_src_r == HBI_SRC_HUB || buf_pci_r);
    assign enc = hbi_encode(buf_data_r);

    // Host line requests win over messages; a waiting message costs only latency
    always_ff @(posedge link.link_clk) begin
        if (lrst_r) begin
            state_r <= HBI_D_IDLE;
            pend_r <= 1'b0;
            ack_tgl_r <= 1'b0;
            dev_data_oe_r <= 1'b0;
            dev_data_r <= HBI_LINE_IDLE;
            dev_flag_r <= HBI_FLAG_IDLE;
            dev_gnt_r <= 1'b0;
            msg_strobe_r <= 1'b0;
            msg_addr_r <= '0;
        end else begin
            case (state_r)
                HBI_D_IDLE: begin
                    if (link.host_req) begin
                        state_r <= HBI_D_GRANT;
                        dev_gnt_r <= 1'b1;
                    end else if (irq_hit) begin
                        state_r <= HBI_D_SEND;
                        dev_data_oe_r <= 1'b1;
                        dev_data_r <= enc[HBI_DATA_W-1:0];
                        dev_flag_r <= enc[HBI_DATA_W +: HBI_LANES];
                        msg_strobe_r <= 1'b1;
                        msg_addr_r <= buf_addr_r;
                    end else if (pend_r) begin
                        pend_r <= 1'b0; // Non-interrupt write leaves by other paths
                        ack_tgl_r <= ~ack_tgl_r;
                    end
                end
                HBI_D_GRANT: begin
                    if (!link.host_req) begin
                        state_r <= HBI_D_IDLE;
                        dev_gnt_r <= 1'b0;
                    end
                end
                HBI_D_SEND: begin
                    state_r <= HBI_D_IDLE;
                    dev_data_oe_r <= 1'b0;
                    dev_data_r <= HBI_LINE_IDLE;
                    dev_flag_r <= HBI_FLAG_IDLE;
                    msg_strobe_r <= 1'b0;
                    pend_r <= 1'b0;
                    ack_tgl_r <= ~ack_tgl_r;
                end
                default: begin
                    state_r <= HBI_D_IDLE;
                end
            endcase
            // Set comes last so a fresh posting is never lost to a same-cycle clear
            if (req_edge) begin
                pend_r <= 1'b1;
            end
        end
    end

    // Every host phase is decoded with its own flags
    always_ff @(posedge link.link_clk) begin
        if (lrst_r) begin
            rx_valid_r <= 1'b0;
            rx_data_r <= '0;
            rx_phase_r <= '0;
            phase_cnt_r <= '0;
        end else if (link.host_data_oe) begin
            rx_valid_r <= 1'b1;
            rx_data_r <= hbi_decode(link.host_data_line_n, link.lane_invert_flag_n);
            rx_phase_r <= phase_cnt_r;
            phase_cnt_r <= phase_cnt_r + 3'h1;
        end else begin
            rx_valid_r <= 1'b0;
            phase_cnt_r <= '0;
        end
    end

endmodule : hbi_dev_end

// ---- src/hbi_host_end.sv ----
`timescale 1ns/1ps
module hbi_host_end import hbi_pkg::*; (
    input wire logic clock,
    input wire logic rst,
    hbi_link_if.host link,
    input wire logic line_valid,
    output logic line_ready_r,
    input wire logic [HBI_LINE_W-1:0] line_data,
    output logic irq_valid_r,
    output logic [HBI_ADDR_W-1:0] irq_addr_r,
    output logic [HBI_DATA_W-1:0] irq_data_r
);
    logic [HBI_LINE_W-1:0] line_buf_r;
    logic req_tgl_r;
    logic ack_s1_r;
    logic ack_s2_r;
    logic ack_s3_r;
    logic msg_s1_r;
    logic msg_s2_r;
    logic msg_s3_r;
    logic lrst_s1_r;
    logic lrst_r;
    logic req_s1_r;
    logic req_s2_r;
    logic req_s3_r;
    logic ack_tgl_r;
    logic msg_tgl_r;
    logic pend_r;
    logic [HBI_ADDR_W-1:0] msg_addr_r;
    logic [HBI_DATA_W-1:0] msg_data_r;
    logic [HBI_PHASE_W-1:0] phase_r;
    logic [HBI_DATA_W+HBI_LANES-1:0] enc;
    hbi_host_state_t state_r;
    logic host_req_r;
    logic host_data_oe_r;
    logic [HBI_DATA_W-1:0] host_data_r;
    logic [HBI_LANES-1:0] host_flag_r;

    assign link.host_req = host_req_r;
    assign link.host_data_oe = host_data_oe_r;
    assign link.host_data_o = host_data_r;
    assign link.host_flag_o = host_flag_r;

    always_ff @(posedge clock) begin
        if (rst) begin
            line_ready_r <= 1'b1;
            req_tgl_r <= 1'b0;
        end else if (line_valid && line_ready_r) begin
            line_ready_r <= 1'b0;
            req_tgl_r <= ~req_tgl_r;
            line_buf_r <= line_data;
        end else if (ack_s2_r ^ ack_s3_r) begin
            line_ready_r <= 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            ack_s1_r <= 1'b0;
            ack_s2_r <= 1'b0;
            ack_s3_r <= 1'b0;
            msg_s1_r <= 1'b0;
            msg_s2_r <= 1'b0;
            msg_s3_r <= 1'b0;
        end else begin
            ack_s1_r <= ack_tgl_r;
            ack_s2_r <= ack_s1_r;
            ack_s3_r <= ack_s2_r;
            msg_s1_r <= msg_tgl_r;
            msg_s2_r <= msg_s1_r;
            msg_s3_r <= msg_s2_r;
        end
    end

    // Message words are held on the link side until the next message, so they are stable here
    always_ff @(posedge clock) begin
        if (rst) begin
            irq_valid_r <= 1'b0;
            irq_addr_r <= '0;
            irq_data_r <= '0;
        end else begin
            irq_valid_r <= msg_s2_r ^ msg_s3_r;
            if (msg_s2_r ^ msg_s3_r) begin
                irq_addr_r <= msg_addr_r;
                irq_data_r <= msg_data_r;
            end
        end
    end

    always_ff @(posedge link.link_clk) begin
        lrst_s1_r <= rst;
        lrst_r <= lrst_s1_r;
    end

    always_ff @(posedge link.link_clk) begin
        if (lrst_r) begin
            req_s1_r <= 1'b0;
            req_s2_r <= 1'b0;
            req_s3_r <= 1'b0;
        end else begin
            req_s1_r <= req_tgl_r;
            req_s2_r <= req_s1_r;
            req_s3_r <= req_s2_r;
        end
    end

    // Interrupts arrive only as bus message transactions
    always_ff @(posedge link.link_clk) begin
        if (lrst_r) begin
            msg_tgl_r <= 1'b0;
            msg_addr_r <= '0;
            msg_data_r <= '0;
        end else if (link.msg_strobe) begin
            msg_tgl_r <= ~msg_tgl_r;
            msg_addr_r <= link.msg_addr;
            msg_data_r <= hbi_decode(link.host_data_line_n, link.lane_invert_flag_n);
        end
    end

    assign enc = hbi_encode(line_buf_r[phase_r*HBI_DATA_W +: HBI_DATA_W]);

    always_ff @(posedge link.link_clk) begin
        if (lrst_r) begin
            state_r <= HBI_H_IDLE;
            pend_r <= 1'b0;
            ack_tgl_r <= 1'b0;
            phase_r <= '0;
            host_req_r <= 1'b0;
            host_data_oe_r <= 1'b0;
            host_data_r <= HBI_LINE_IDLE;
            host_flag_r <= HBI_FLAG_IDLE;
        end else begin
            case (state_r)
                HBI_H_IDLE: begin
                    // A stale grant from the last line must drop before asking again
                    if (pend_r && !link.dev_gnt) begin
                        state_r <= HBI_H_REQ;
                        host_req_r <= 1'b1;
                    end
                end
                HBI_H_REQ: begin
                    if (link.dev_gnt && !link.dev_data_oe) begin
                        state_r <= HBI_H_DRIVE;
                        host_data_oe_r <= 1'b1;
                        host_data_r <= enc[HBI_DATA_W-1:0];
                        host_flag_r <= enc[HBI_DATA_W +: HBI_LANES];
                        phase_r <= phase_r + 3'h1;
                    end
                end
                HBI_H_DRIVE: begin
                    if (phase_r == '0) begin
                        state_r <= HBI_H_IDLE;
                        host_req_r <= 1'b0;
                        host_data_oe_r <= 1'b0;
                        host_data_r <= HBI_LINE_IDLE;
                        host_flag_r <= HBI_FLAG_IDLE;
                        pend_r <= 1'b0;
                        ack_tgl_r <= ~ack_tgl_r;
                    end else begin
                        host_data_r <= enc[HBI_DATA_W-1:0];
                        host_flag_r <= enc[HBI_DATA_W +: HBI_LANES];
                        phase_r <= (phase_r == HBI_LAST_PHASE) ? '0 : phase_r + 3'h1;
                    end
                end
                default: begin
                    state_r <= HBI_H_IDLE;
                end
            endcase
            // Set comes last so a fresh line is never lost to a same-cycle clear
            if (req_s2_r ^ req_s3_r) begin
                pend_r <= 1'b1;
            end
        end
    end

endmodule : hbi_host_end

// ---- test/hbi_link_checker.sv ----
`timescale 1ns/1ps
module hbi_link_checker import hbi_pkg::*; (
    input wire logic link_clk,
    input wire logic rst,
    input wire logic dev_data_oe,
    input wire logic host_data_oe,
    input wire logic [HBI_DATA_W-1:0] host_data_line_n,
    input wire logic [HBI_LANES-1:0] lane_invert_flag_n,
    input wire logic host_req,
    input wire logic dev_gnt,
    input wire logic msg_strobe,
    input wire logic [HBI_ADDR_W-1:0] msg_addr
);
    default clocking cb @(posedge link_clk);
    endclocking
    default disable iff (rst);

    // Strict: an asserted flag needs more than eight high lines; otherwise at most eight lines low
    function automatic bit lanes_ok(input logic [63:0] l, input logic [3:0] f, input bit strict);
        bit ok;
        int n;
        ok = 1'b1;
        for (int i = 0; i < HBI_LANES; i++) begin
            n = $countones(l[i*HBI_LANE_W +: HBI_LANE_W]);
            if (strict && !f[i] && n <= HBI_LOW_LIMIT) ok = 1'b0;
            if (!strict && n < HBI_LANE_W - HBI_LOW_LIMIT) ok = 1'b0;
        end
        return ok;
    endfunction : lanes_ok

    sequence line_burst;
        host_data_oe [*8] ##1 !host_data_oe;
    endsequence

    sequence grant_ack;
        ##[1:4] dev_gnt;
    endsequence

    sequence one_phase_msg;
        dev_data_oe ##1 !dev_data_oe;
    endsequence

    low_limit_a: assert property ((dev_data_oe || host_data_oe) |-> lanes_ok(host_data_line_n, lane_invert_flag_n, 1'b0))
        else $error("more than eight low lines in a lane");
    flag_match_a: assert property ((dev_data_oe || host_data_oe) |-> lanes_ok(host_data_line_n, lane_invert_flag_n, 1'b1))
        else $error("lane flag asserted without cause");
    one_driver_a: assert property (!(dev_data_oe && host_data_oe))
        else $error("both ends drive the lines");
    line_phases_a: assert property ($rose(host_data_oe) |-> line_burst)
        else $error("line not eight phases");
    host_gnt_a: assert property (host_data_oe |-> dev_gnt)
        else $error("host drives without grant");
    grant_wait_a: assert property ($rose(host_req) |-> grant_ack)
        else $error("grant too late");
    strobe_pulse_a: assert property (msg_strobe |=> !msg_strobe)
        else $error("message strobe longer than one cycle");
    strobe_window_a: assert property (msg_strobe |-> msg_addr[HBI_WIN_HI:HBI_WIN_LO] == HBI_IRQ_WINDOW)
        else $error("message outside interrupt window");
    strobe_drive_a: assert property (msg_strobe |-> one_phase_msg)
        else $error("message data phase wrong");
endmodule : hbi_link_checker

// ---- test/testbench.sv ----
`timescale 1ns/1ps
module testbench import hbi_pkg::*;;
    logic clock, link_clk, rst, in_valid, in_src, in_pci_sem, line_valid;
    logic in_ready_r, rx_valid_r, line_ready_r, irq_valid_r;
    logic [31:0] in_addr, irq_addr_r;
    logic [63:0] in_data, rx_data_r, irq_data_r;
    logic [2:0] rx_phase_r;
    logic [511:0] line_data;
    int n_errors, samples_checked, cycles;
    logic [67:0] wq[$], rq[$], mq[$];
    logic [31:0] maq[$];
    logic [95:0] iq[$];

    hbi_link_if hbi_link_if_i (.link_clk(link_clk));
    hbi_dev_end hbi_dev_end_i (.clock(clock), .rst(rst), .link(hbi_link_if_i), .in_valid(in_valid),
        .in_ready_r(in_ready_r), .in_addr(in_addr), .in_data(in_data), .in_src(in_src), .in_pci_sem(in_pci_sem),
        .rx_valid_r(rx_valid_r), .rx_data_r(rx_data_r), .rx_phase_r(rx_phase_r));
    hbi_host_end hbi_host_end_i (.clock(clock), .rst(rst), .link(hbi_link_if_i), .line_valid(line_valid),
        .line_ready_r(line_ready_r), .line_data(line_data), .irq_valid_r(irq_valid_r),
        .irq_addr_r(irq_addr_r), .irq_data_r(irq_data_r));
    hbi_link_checker hbi_link_checker_i (.link_clk(link_clk), .rst(rst),
        .dev_data_oe(hbi_link_if_i.dev_data_oe), .host_data_oe(hbi_link_if_i.host_data_oe),
        .host_data_line_n(hbi_link_if_i.host_data_line_n), .lane_invert_flag_n(hbi_link_if_i.lane_invert_flag_n),
        .host_req(hbi_link_if_i.host_req), .dev_gnt(hbi_link_if_i.dev_gnt),
        .msg_strobe(hbi_link_if_i.msg_strobe), .msg_addr(hbi_link_if_i.msg_addr));

    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    // A 30 ns link period against the 25 ns core period keeps the link edges drifting against the core clock
    initial begin
        link_clk = 1'b0;
        #7;
        forever #15 link_clk = ~link_clk;
    end

    always @(posedge link_clk) begin
        if (hbi_link_if_i.host_data_oe) wq.push_back({hbi_link_if_i.lane_invert_flag_n, hbi_link_if_i.host_data_line_n});
        if (hbi_link_if_i.msg_strobe) mq.push_back({hbi_link_if_i.lane_invert_flag_n, hbi_link_if_i.host_data_line_n});
        if (hbi_link_if_i.msg_strobe) maq.push_back(hbi_link_if_i.msg_addr);
        if (rx_valid_r) rq.push_back({1'b0, rx_phase_r, rx_data_r});
    end

    always @(posedge clock) begin
        cycles++;
        if (irq_valid_r) iq.push_back({irq_addr_r, irq_data_r});
        if (cycles == 8000) begin
            n_errors++;
            wrap_up();
        end
    end

    task automatic chk(input string what, input logic [67:0] seen, input logic [67:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    function automatic logic [67:0] enc(input logic [63:0] d);
        logic [67:0] r;
        r = {4'hf, ~d};
        for (int i = 0; i < 4; i++) begin
            if ($countones(d[i*16 +: 16]) > HBI_LOW_LIMIT) begin
                r[i*16 +: 16] = d[i*16 +: 16];
                r[64 + i] = 1'b0;
            end
        end
        return r;
    endfunction : enc

    // Lane values sit on both sides of the eight-ones boundary and rotate through every lane
    function automatic logic [63:0] pat(input int k);
        logic [15:0] pv [8] = '{16'h00ff, 16'h01ff, 16'hffff, 16'h0000, 16'hff7f, 16'h8001, 16'hfe00, 16'h5aa5};
        logic [63:0] r;
        for (int j = 0; j < 4; j++) r[j*16 +: 16] = pv[(k + j) % 8];
        return r;
    endfunction : pat

    task automatic wait_ready(input bit host);
        for (int i = 0; i < 200 && (host ? line_ready_r : in_ready_r) !== 1'b1; i++) @(negedge clock);
    endtask : wait_ready

    task automatic t_line(input int s);
        wq.delete();
        rq.delete();
        wait_ready(1'b1);
        for (int k = 0; k < 8; k++) line_data[k*64 +: 64] = pat(k + s);
        line_valid = 1'b1;
        @(negedge clock);
        line_valid = 1'b0;
        chk("line ready after take", 68'(line_ready_r), 68'h0);
        wait_ready(1'b1);
        repeat (4) @(negedge clock);
        chk("line phase count", 68'(wq.size()), 68'h8);
        chk("received phase count", 68'(rq.size()), 68'h8);
        for (int k = 0; k < 8; k++) begin
            chk("wire phase", wq[k], enc(pat(k + s)));
            chk("received phase", rq[k], {1'b0, 3'(k), pat(k + s)});
        end
    endtask : t_line

    task automatic t_write(input logic [31:0] a, input logic [63:0] d, input logic s, input logic p,
                           input logic hit, input logic retry);
        mq.delete();
        maq.delete();
        iq.delete();
        wait_ready(1'b0);
        {in_addr, in_data, in_src, in_pci_sem, in_valid} = {a, d, s, p, 1'b1};
        @(negedge clock);
        in_data = ~d;
        in_valid = retry;
        chk("write ready after take", 68'(in_ready_r), 68'h0);
        repeat (3) @(negedge clock);
        in_valid = 1'b0;
        wait_ready(1'b0);
        repeat (12) @(negedge clock);
        chk("message count", 68'(mq.size()), 68'(hit));
        chk("interrupt count", 68'(iq.size()), 68'(hit));
        if (hit) begin
            chk("message address", 68'(maq[0]), 68'(a));
            chk("message wire", mq[0], enc(d));
            chk("interrupt address", 68'(iq[0][95:64]), 68'(a));
            chk("interrupt data", 68'(iq[0][63:0]), 68'(d));
        end
    endtask : t_write

    task automatic wrap_up;
        if (n_errors == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : wrap_up

    // Four core cycles still give the link side three reset edges through its synchroniser
    initial begin
        {rst, in_valid, in_src, in_pci_sem, line_valid} = 5'h10;
        {in_addr, in_data, line_data} = '0;
        repeat (4) @(negedge clock);
        rst = 1'b0;
        t_line(0);
        t_line(3);
        t_write(32'hfee0_0000, 64'h01ff_00ff_ffff_0000, HBI_SRC_HUB, 1'b0, 1'b1, 1'b1);
        t_write(32'hfeef_ffff, 64'hfe00_5aa5_8001_ff7f, HBI_SRC_GFX, 1'b1, 1'b1, 1'b0);
        t_write(32'hfee1_2345, 64'h0123_4567_89ab_cdef, HBI_SRC_GFX, 1'b0, 1'b0, 1'b0);
        t_write(32'hfef0_0000, 64'hffff_0000_ffff_0000, HBI_SRC_HUB, 1'b1, 1'b0, 1'b0);
        t_write(32'hfedf_ffff, 64'h00ff_01ff_00ff_01ff, HBI_SRC_HUB, 1'b0, 1'b0, 1'b0);
        t_line(5);
        wrap_up();
    end
endmodule : testbench
